// ===== hdl/acq_pkg.sv
// Shared constants and types of the acquisition sequencer
package acq_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int BUS_W = 32;
	localparam int REG_W = 16;
	localparam int NUM_INSTR = 8;
	localparam int NUM_SECT = 3;
	localparam int FIFO_DEPTH_DOC = 32;
	localparam int FIFO_DEPTH_MAX = 32;
	localparam int SMP_W = 13;
	localparam int SMP8_LSB = 4;
	localparam int STAT_W = 8;

	// ****************************************
	// Register locations, address fields
	// ****************************************
	localparam int LOC_W = 4;
	localparam int LOC_LSB = 3;
	localparam int LOC_MSB = 6;
	localparam int BYTE_SEL_BIT = 2;
	localparam logic [3:0] LOC_CONFIG = 4'h8;
	localparam logic [3:0] LOC_INTEN = 4'h9;
	localparam logic [3:0] LOC_INTSTAT = 4'ha;
	localparam logic [3:0] LOC_TIMER = 4'hb;
	localparam logic [3:0] LOC_FIFO = 4'hc;
	localparam logic [3:0] LOC_LIMSTAT = 4'hd;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic WIDTH_8BIT = 1'b0;

	// ****************************************
	// Reset values, status bits
	// ****************************************
	localparam logic [15:0] REG_ZERO = 16'h0000;
	localparam logic [15:0] DLY_LAST = 16'h0001;
	localparam logic [7:0] STAT_ZERO = 8'h00;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	localparam int ST_LIMIT = 0;
	localparam int ST_INSTR = 1;
	localparam int ST_READY = 2;
	localparam int ST_CAL = 3;
	localparam int ST_OVF = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {MODE_CONV12 = 2'b00, MODE_CONV8 = 2'b01, MODE_WATCH = 2'b10,
		MODE_RSVD = 2'b11} op_mode_t;
	typedef enum logic [1:0] {SEC_INSTR = 2'b00, SEC_LIM1 = 2'b01, SEC_LIM2 = 2'b10,
		SEC_NONE = 2'b11} section_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_DELAY = 2'b01, ST_ISSUE = 2'b10,
		ST_WAIT = 2'b11} seq_state_t;
	typedef struct packed {logic [5:0] spare; logic [3:0] acq_len; logic timer_en;
		op_mode_t mode; logic [2:0] channel;} instr_t;
	typedef struct packed {logic [5:0] spare; logic high_bound; logic signed [8:0] value;} limit_t;
	typedef struct packed {logic [6:0] spare; logic [2:0] last_instr; section_t section_pointer;
		logic cal; logic standby; logic reset; logic start;} cfg_t;
	typedef struct packed {logic [2:0] instr_num; logic [4:0] ready_count;
		logic [7:0] enable;} inten_t;
	typedef struct packed {logic [2:0] channel; op_mode_t mode; logic [3:0] acq_len;} conv_req_t;

endpackage : acq_pkg

// ===== hdl/result_fifo.sv
// Result FIFO with independent write and read pointers
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input logic clk_sys,
	input logic rstn,
	input logic clr,
	input logic push,
	input logic [WIDTH-1:0] push_data,
	input logic pop,
	output logic [WIDTH-1:0] head,
	output logic [$clog2(DEPTH):0] count,
	output logic full
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("result_fifo: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;

	wire pop_ok_w = pop & (cnt_ff != '0);
	wire inc_w = push & (~full | pop_ok_w);
	assign full = (cnt_ff == (AW + 1)'(DEPTH));
	assign head = mem_ff[rd_ff];
	assign count = cnt_ff;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_ff[wr_ff] <= push_data;
		end
	end

	// Pointers wrap on their own; neither side moves the other
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else if (clr) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop_ok_w) begin
				rd_ff <= rd_ff + 1'b1;
			end
			if (inc_w && !pop_ok_w) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (!inc_w && pop_ok_w) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end

endmodule : result_fifo

// ===== hdl/acq_sequencer_top.sv
// Acquisition sequencer control with AHB-Lite register port
//
// Contract
// - Three per-instruction modes: 12-bit conversion, 8-bit conversion, watchdog compare.
// - Watchdog samples without storing, flags fault when sample lies beyond a limit.
// - Eight instruction entries, each three separately addressed 16-bit sections.
// - Two-bit section pointer: 00 instruction, 01 first limit, 10 second limit.
// - Instruction section holds channel, mode and acquisition length used when run.
// - Each limit is independently a low or high bound.
// - Run instruction 0 up to last programmed, wrap to 0, loop until stopped.
// - Conversions go into a 32-entry read-only FIFO; write pointer advances, wraps.
// - Read pointer advances on each host read; pointers never move each other. This design leaves it in place on a read of an empty FIFO.
// - Configuration bits start, stop, reset, standby, calibrate, select section.
// - Eight interrupt enables; interrupt output only for enabled conditions.
// - Data-ready raised once FIFO holds programmed count of results.
// - Condition raised when sequencer reaches programmed instruction number.
// - Read-only interrupt status and limit status report events and crossed limits.
// - Status bit sets on its condition even when not enabled.
// - Sixteen-bit timer delays an instruction when its per-instruction bit is set.
// - Every register readable, most also writable, through the register port.
// - Start written together with other configuration bits; all apply at start.
// - Narrow mode takes two byte accesses, low address bit picks byte.
// - Fourteen 16-bit locations, or twenty-eight 8-bit locations in narrow mode.
// - Internal sequencing pauses while a host access is in progress; this design still takes conv_done in the wait state.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module acq_sequencer_top #(
	parameter int FIFO_DEPTH = acq_pkg::FIFO_DEPTH_DOC
) (
	input logic clk_sys,
	input logic rstn,
	input logic hsel,
	input logic [acq_pkg::BUS_W-1:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [acq_pkg::BUS_W-1:0] hwdata,
	input logic hready,
	output logic [acq_pkg::BUS_W-1:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input logic access_width_select,
	output acq_pkg::conv_req_t conv_req,
	output logic conv_start,
	input logic conv_done,
	input logic [acq_pkg::SMP_W-1:0] conv_sample,
	output logic cal_start,
	input logic cal_done,
	output logic standby,
	output logic irq
);
	import acq_pkg::*;

	localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > FIFO_DEPTH_MAX) begin : g_bad_depth
		$error("acq_sequencer_top: FIFO_DEPTH out of range");
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [BUS_W-1:0] place(input logic [REG_W-1:0] w, input logic hi,
		input logic narrow);
		if (narrow) begin
			return {24'h00_0000, hi ? w[15:8] : w[7:0]};
		end
		return {16'h0000, w};
	endfunction : place

	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] wd, input logic hi, input logic narrow);
		if (!narrow) begin
			return wd;
		end
		return hi ? {wd[7:0], old[7:0]} : {old[15:8], wd[7:0]};
	endfunction : merge

	function automatic logic beyond(input logic signed [8:0] smp, input limit_t lim);
		return lim.high_bound ? (smp > lim.value) : (smp < lim.value);
	endfunction : beyond

	// ****************************************
	// State
	// ****************************************
	cfg_t cfg_ff;
	cfg_t nxt_cfg;
	inten_t inten_ff;
	logic [REG_W-1:0] timer_ff;
	logic [STAT_W-1:0] intstat_ff;
	logic [STAT_W-1:0] nxt_intstat;
	logic [STAT_W-1:0] stat_set_w;
	logic [REG_W-1:0] limstat_ff;
	logic [REG_W-1:0] nxt_limstat;
	logic [REG_W-1:0] mem_ff [NUM_SECT][NUM_INSTR];
	logic wr_pend_ff;
	logic [LOC_W-1:0] wr_loc_ff;
	logic wr_hi_ff;
	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic [2:0] pc_ff;
	logic [2:0] nxt_pc;
	logic [REG_W-1:0] dly_ff;
	logic [REG_W-1:0] nxt_dly;
	logic [REG_W-1:0] fifo_head_w;
	logic [CNT_W-1:0] fifo_count_w;
	logic fifo_full_w;

	// ****************************************
	// Address phase decode
	// ****************************************
	wire acc_w = hsel & hready & (htrans == HTRANS_NONSEQ);
	wire narrow_w = (access_width_select == WIDTH_8BIT);
	wire [LOC_W-1:0] loc_w = haddr[LOC_MSB:LOC_LSB];
	wire hi_w = narrow_w & haddr[BYTE_SEL_BIT];
	wire last_byte_w = ~narrow_w | hi_w;
	wire rd_w = acc_w & ~hwrite;
	wire sp_ok_w = (cfg_ff.section_pointer != SEC_NONE);
	wire is_mem_w = (loc_w < LOC_CONFIG);
	wire [REG_W-1:0] mem_rd_w = sp_ok_w ? mem_ff[cfg_ff.section_pointer][loc_w[2:0]] : REG_ZERO;

	// Fourteen locations, all readable
	wire [REG_W-1:0] rd_word_w = is_mem_w ? mem_rd_w :
		(loc_w == LOC_CONFIG) ? cfg_ff :
		(loc_w == LOC_INTEN) ? inten_ff :
		(loc_w == LOC_INTSTAT) ? {STAT_ZERO, intstat_ff} :
		(loc_w == LOC_TIMER) ? timer_ff :
		(loc_w == LOC_FIFO) ? fifo_head_w :
		(loc_w == LOC_LIMSTAT) ? limstat_ff : REG_ZERO;

	// FIFO and status pop on the last byte of a read
	wire pop_w = rd_w & (loc_w == LOC_FIFO) & last_byte_w;
	wire rd_stat_w = rd_w & (loc_w == LOC_INTSTAT) & last_byte_w;
	wire rd_lim_w = rd_w & (loc_w == LOC_LIMSTAT) & last_byte_w;

	// ****************************************
	// Data phase writes
	// ****************************************
	wire wr_cfg_w = wr_pend_ff & (wr_loc_ff == LOC_CONFIG);
	wire wr_ie_w = wr_pend_ff & (wr_loc_ff == LOC_INTEN);
	wire wr_tmr_w = wr_pend_ff & (wr_loc_ff == LOC_TIMER);
	wire wr_mem_w = wr_pend_ff & (wr_loc_ff < LOC_CONFIG) & sp_ok_w;
	wire [REG_W-1:0] wd_w = hwdata[REG_W-1:0];
	wire clr_w = cfg_ff.reset;
	wire stall_w = acc_w | wr_pend_ff;

	// Reset and calibrate are one-shot commands
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_cfg.reset = 1'b0;
		nxt_cfg.cal = 1'b0;
		if (wr_cfg_w) begin
			nxt_cfg = cfg_t'(merge(cfg_ff, wd_w, wr_hi_ff, narrow_w));
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	instr_t cur_w;
	limit_t lim1_w;
	limit_t lim2_w;
	assign cur_w = instr_t'(mem_ff[SEC_INSTR][pc_ff]);
	assign lim1_w = limit_t'(mem_ff[SEC_LIM1][pc_ff]);
	assign lim2_w = limit_t'(mem_ff[SEC_LIM2][pc_ff]);

	wire go_w = (state_ff == ST_IDLE) & cfg_ff.start & ~cfg_ff.standby & ~stall_w & ~clr_w;
	wire done_w = (state_ff == ST_WAIT) & conv_done & ~clr_w;
	wire watch_w = (cur_w.mode == MODE_WATCH);
	wire push_w = done_w & ~watch_w;
	wire wd_evt_w = done_w & watch_w;
	wire signed [8:0] smp9_w = conv_sample[SMP_W-1:SMP8_LSB];
	wire f1_w = wd_evt_w & beyond(smp9_w, lim1_w);
	wire f2_w = wd_evt_w & beyond(smp9_w, lim2_w);
	wire [2:0] pc_next_w = (pc_ff == cfg_ff.last_instr) ? 3'h0 : pc_ff + 1'b1;
	wire need_dly_w = cur_w.timer_en & (timer_ff != REG_ZERO);
	wire [NUM_INSTR-1:0] pc_hot_w = 8'h01 << pc_ff;

	// Stop only from idle, so an instruction finishes unless the reset command aborts it
	always_comb begin
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_dly = dly_ff;
		if (clr_w) begin
			nxt_state = ST_IDLE;
			nxt_pc = 3'h0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (go_w && need_dly_w) begin
						nxt_state = ST_DELAY;
						nxt_dly = timer_ff;
					end else if (go_w) begin
						nxt_state = ST_ISSUE;
					end
				end
				ST_DELAY: begin
					if (!stall_w && dly_ff == DLY_LAST) begin
						nxt_state = ST_ISSUE;
					end else if (!stall_w) begin
						nxt_dly = dly_ff - 1'b1;
					end
				end
				ST_ISSUE: begin
					if (!stall_w) begin
						nxt_state = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (conv_done) begin
						nxt_state = ST_IDLE;
						nxt_pc = pc_next_w;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Status
	// ****************************************
	wire ready_w = (fifo_count_w != '0) && (fifo_count_w >= CNT_W'(inten_ff.ready_count));
	assign stat_set_w[ST_LIMIT] = f1_w | f2_w;
	assign stat_set_w[ST_INSTR] = go_w & (pc_ff == inten_ff.instr_num);
	assign stat_set_w[ST_READY] = ready_w & ~clr_w;
	assign stat_set_w[ST_CAL] = cal_done;
	assign stat_set_w[ST_OVF] = push_w & fifo_full_w;
	assign stat_set_w[STAT_W-1:ST_OVF+1] = '0;

	// Set wins over clear; set regardless of enable
	assign nxt_intstat = (intstat_ff & ~{STAT_W{clr_w | rd_stat_w}}) | stat_set_w;
	assign nxt_limstat = (limstat_ff & ~{REG_W{clr_w | rd_lim_w}}) |
		{f2_w ? pc_hot_w : STAT_ZERO, f1_w ? pc_hot_w : STAT_ZERO};

	// ****************************************
	// Result FIFO
	// ****************************************
	result_fifo #(.WIDTH(REG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clr(clr_w),
		.push(push_w),
		.push_data({pc_ff, conv_sample}),
		.pop(pop_w),
		.head(fifo_head_w),
		.count(fifo_count_w),
		.full(fifo_full_w)
	);

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_pend_ff <= 1'b0;
			wr_loc_ff <= '0;
			wr_hi_ff <= 1'b0;
			hrdata <= RDATA_ZERO;
		end else begin
			wr_pend_ff <= acc_w & hwrite;
			wr_loc_ff <= loc_w;
			wr_hi_ff <= hi_w;
			hrdata <= rd_w ? place(rd_word_w, hi_w, narrow_w) : RDATA_ZERO;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_ff <= cfg_t'(REG_ZERO);
			inten_ff <= inten_t'(REG_ZERO);
			timer_ff <= REG_ZERO;
			intstat_ff <= STAT_ZERO;
			limstat_ff <= REG_ZERO;
		end else begin
			cfg_ff <= nxt_cfg;
			intstat_ff <= nxt_intstat;
			limstat_ff <= nxt_limstat;
			if (wr_ie_w) begin
				inten_ff <= inten_t'(merge(inten_ff, wd_w, wr_hi_ff, narrow_w));
			end
			if (wr_tmr_w) begin
				timer_ff <= merge(timer_ff, wd_w, wr_hi_ff, narrow_w);
			end
		end
	end

	// Memory is untouched by the reset command
	always_ff @(posedge clk_sys) begin
		if (wr_mem_w) begin
			mem_ff[cfg_ff.section_pointer][wr_loc_ff[2:0]] <=
				merge(mem_ff[cfg_ff.section_pointer][wr_loc_ff[2:0]], wd_w, wr_hi_ff, narrow_w);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			pc_ff <= 3'h0;
			dly_ff <= REG_ZERO;
		end else begin
			state_ff <= nxt_state;
			pc_ff <= nxt_pc;
			dly_ff <= nxt_dly;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			conv_start <= 1'b0;
			conv_req <= '0;
			cal_start <= 1'b0;
			standby <= 1'b0;
			irq <= 1'b0;
			hreadyout <= 1'b0;
			hresp <= HRESP_OKAY;
		end else begin
			conv_start <= (state_ff == ST_ISSUE) & ~stall_w & ~clr_w;
			if (state_ff == ST_ISSUE) begin
				conv_req <= '{channel: cur_w.channel, mode: cur_w.mode, acq_len: cur_w.acq_len};
			end
			cal_start <= cfg_ff.cal;
			standby <= cfg_ff.standby;
			irq <= |(nxt_intstat & inten_ff.enable);
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	AST_WATCH_NO_STORE: assert property (
		(wd_evt_w && !pop_w) |=> fifo_count_w == $past(fifo_count_w))
		else $error("Watchdog instruction changed FIFO count");

	AST_LOOP_WRAP: assert property (
		(done_w && pc_ff == cfg_ff.last_instr) |=> pc_ff == 3'h0)
		else $error("Sequencer did not wrap to instruction 0");

	AST_LOOP_STEP: assert property (
		(done_w && pc_ff != cfg_ff.last_instr) |=> pc_ff == $past(pc_ff) + 3'h1)
		else $error("Sequencer did not advance by one");

	AST_IRQ_MASKED: assert property (
		irq |-> |(intstat_ff & $past(inten_ff.enable)))
		else $error("Interrupt raised without enabled status");

	AST_CAL_STICKY: assert property (
		cal_done |=> intstat_ff[ST_CAL])
		else $error("Calibration status not set");

	AST_RESET_CMD: assert property (
		clr_w |=> (pc_ff == 3'h0) && (state_ff == ST_IDLE) && (fifo_count_w == '0))
		else $error("Reset command did not clear sequencer and FIFO");

	AST_STOP_IDLE: assert property (
		(state_ff == ST_IDLE && !cfg_ff.start) |=> state_ff == ST_IDLE)
		else $error("Sequencer left idle while stopped");

	AST_STALL_TIMER: assert property (
		(stall_w && state_ff == ST_DELAY && !clr_w) |=> $stable(dly_ff) && state_ff == ST_DELAY)
		else $error("Delay advanced during host access");

	AST_READY_SET: assert property (
		(ready_w && !clr_w) |=> intstat_ff[ST_READY])
		else $error("Data-ready not raised at threshold");

	AST_ISSUE_FIELDS: assert property (
		conv_start |-> conv_req.channel == cur_w.channel && conv_req.mode == cur_w.mode)
		else $error("Issued request does not match instruction");

endmodule : acq_sequencer_top

// ===== verification/conv_model.sv
// Behavioural converter that answers the sequencer's conversion and calibration requests
`timescale 1ns/1ps
module conv_model (
	input logic clk_sys,
	input logic rstn,
	input acq_pkg::conv_req_t conv_req,
	input logic conv_start,
	input logic cal_start,
	input logic [3:0] lat,
	input logic [12:0] smp_base,
	output logic conv_done,
	output logic [12:0] conv_sample,
	output logic cal_done
);
	import acq_pkg::*;

	// ****************************************
	// Conversion and calibration timing
	// ****************************************
	logic busy_ff;
	logic [3:0] cnt_ff;
	logic [2:0] ch_ff;
	logic [1:0] cal_cnt_ff;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			busy_ff <= 1'b0;
			cnt_ff <= 4'h0;
			ch_ff <= 3'h0;
			cal_cnt_ff <= 2'h0;
			conv_done <= 1'b0;
			cal_done <= 1'b0;
			conv_sample <= 13'h0aaa;
		end else begin
			conv_done <= 1'b0;
			cal_done <= 1'b0;
			conv_sample <= ~conv_sample;
			if (conv_start) begin
				busy_ff <= 1'b1;
				cnt_ff <= lat;
				ch_ff <= conv_req.channel;
			end else if (busy_ff && cnt_ff == 4'h0) begin
				busy_ff <= 1'b0;
				conv_done <= 1'b1;
				conv_sample <= smp_base + {6'h00, ch_ff, 4'h0};
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
			if (cal_start) begin
				cal_cnt_ff <= 2'h2;
			end else if (cal_cnt_ff != 2'h0) begin
				cal_cnt_ff <= cal_cnt_ff - 2'h1;
				cal_done <= (cal_cnt_ff == 2'h1);
			end
		end
	end
endmodule : conv_model

// ===== verification/tb_top.sv
// Self-checking bench of the acquisition sequencer control
`timescale 1ns/1ps
module tb_top;
	import acq_pkg::*;
	typedef struct packed {logic wr; logic [3:0] loc; logic [15:0] d;} row_t;

	// ****************************************
	// Signals
	// ****************************************
	logic clk_sys = 1'b0;
	logic rstn, hsel, hwrite, hreadyout, hresp, access_width_select;
	logic conv_start, conv_done, cal_start, cal_done, standby, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, pc_exp;
	logic [3:0] lat;
	logic [12:0] smp_base, conv_sample;
	conv_req_t conv_req;
	logic [15:0] d;
	logic [31:0] exp_q[$];
	int checks = 0, n_mismatch = 0, n_start = 0, n_done = 0, cyc = 0, t_done = 0;
	int gap[0:2];
	logic [15:0] prog[0:2] = '{16'h00e1, 16'h008a, 16'h0055};
	row_t rows[0:30] = '{'{1'b0, LOC_CONFIG, 16'h0000}, '{1'b0, LOC_INTEN, 16'h0000},
		'{1'b0, LOC_TIMER, 16'h0000}, '{1'b1, LOC_TIMER, 16'h1234}, '{1'b0, LOC_TIMER, 16'h1234},
		'{1'b1, 4'he, 16'hffff}, '{1'b0, 4'he, 16'h0000}, '{1'b1, LOC_LIMSTAT, 16'hffff},
		'{1'b0, LOC_LIMSTAT, 16'h0000}, '{1'b1, LOC_CONFIG, 16'h00ba}, '{1'b0, LOC_CONFIG, 16'h00b0},
		'{1'b0, 4'h2, 16'h0000}, '{1'b0, LOC_INTSTAT, 16'h0008}, '{1'b0, LOC_INTSTAT, 16'h0000},
		'{1'b1, LOC_CONFIG, 16'h0002}, '{1'b1, 4'h0, 16'h00e1}, '{1'b1, 4'h1, 16'h008a},
		'{1'b1, 4'h2, 16'h0055}, '{1'b1, LOC_CONFIG, 16'h0010}, '{1'b1, 4'h2, 16'h0205},
		'{1'b1, LOC_CONFIG, 16'h0020}, '{1'b1, 4'h2, 16'h0003}, '{1'b0, 4'h2, 16'h0003},
		'{1'b1, LOC_CONFIG, 16'h0010}, '{1'b0, 4'h2, 16'h0205}, '{1'b1, LOC_CONFIG, 16'h0000},
		'{1'b0, 4'h0, 16'h00e1}, '{1'b0, 4'h2, 16'h0055}, '{1'b1, LOC_INTEN, 16'h2200},
		'{1'b0, LOC_INTEN, 16'h2200}, '{1'b1, LOC_TIMER, 16'h0004}};

	always #12.5 clk_sys = ~clk_sys;

	acq_sequencer_top #(.FIFO_DEPTH(8)) i_acq_sequencer_top (.clk_sys(clk_sys), .rstn(rstn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .access_width_select(access_width_select), .conv_req(conv_req),
		.conv_start(conv_start), .conv_done(conv_done), .conv_sample(conv_sample),
		.cal_start(cal_start), .cal_done(cal_done), .standby(standby), .irq(irq));

	conv_model i_conv_model (.clk_sys(clk_sys), .rstn(rstn), .conv_req(conv_req),
		.conv_start(conv_start), .cal_start(cal_start), .lat(lat), .smp_base(smp_base),
		.conv_done(conv_done), .conv_sample(conv_sample), .cal_done(cal_done));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] expv);
		checks++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, expv, seen);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [6:0] a, input logic [15:0] wd,
		output logic [15:0] rd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {25'h0, a};
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, wd};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata[15:0];
		chk("hresp", {15'h0, hresp}, 16'h0000);
	endtask : bus

	task automatic run(input int n);
		int t;
		logic [15:0] r;
		bus(1'b1, {LOC_CONFIG, 3'h0}, 16'h0081, r);
		t = 0;
		while (n_done < n && t < 5000) begin @(posedge clk_sys); t++; end
		chk("conversions", 16'(n_done >= n), 16'h0001);
		bus(1'b1, {LOC_CONFIG, 3'h0}, 16'h0080, r);
		repeat (30) @(posedge clk_sys);
		t = n_start;
		repeat (40) @(posedge clk_sys);
		chk("stopped", 16'(n_start), 16'(t));
		$display("test run done");
	endtask : run

	task automatic drain;
		logic [31:0] e;
		logic [15:0] r;
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			bus(1'b0, {LOC_FIFO, 3'h0}, 16'h0000, r);
			chk("fifo", r & e[31:16], e[15:0] & e[31:16]);
		end
		$display("test drain done");
	endtask : drain

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// Converter traffic monitor
	// ****************************************
	always @(posedge clk_sys) begin
		cyc++;
		if (conv_start === 1'b1) begin
			n_start++;
			chk("conv_req", {7'h00, conv_req}, {7'h00, prog[pc_exp][2:0], prog[pc_exp][4:3],
				prog[pc_exp][9:6]});
			if (n_done > 0 && n_done <= 3) gap[pc_exp] = cyc - t_done;
		end
		if (conv_done === 1'b1) begin
			t_done = cyc;
			if (prog[pc_exp][4:3] != 2'b10) begin
				exp_q.push_back({(prog[pc_exp][4:3] == 2'b01) ? 16'he000 : 16'hffff, pc_exp,
					13'(smp_base + {6'h00, prog[pc_exp][2:0], 4'h0})});
			end
			pc_exp = (pc_exp == 3'h2) ? 3'h0 : pc_exp + 3'h1;
			n_done++;
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		print_verdict();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		access_width_select = 1'b1;
		lat = 4'h2;
		smp_base = 13'h0100;
		pc_exp = 3'h0;
		rstn = 1'b0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			bus(rows[i].wr, {rows[i].loc, 3'h0}, rows[i].d, d);
			if (!rows[i].wr) chk("reg", d, rows[i].d);
		end
		$display("test registers done");
		bus(1'b1, {LOC_CONFIG, 3'h0}, 16'h0004, d);
		repeat (2) @(posedge clk_sys);
		chk("standby", {15'h0, standby}, 16'h0001);
		bus(1'b1, {LOC_CONFIG, 3'h0}, 16'h0000, d);
		access_width_select <= WIDTH_8BIT;
		bus(1'b1, {LOC_TIMER, 3'h0}, 16'h0077, d);
		bus(1'b1, {LOC_TIMER, 3'h4}, 16'h0012, d);
		bus(1'b0, {LOC_TIMER, 3'h4}, 16'h0000, d);
		chk("high byte", d & 16'h00ff, 16'h0012);
		bus(1'b0, {LOC_TIMER, 3'h0}, 16'h0000, d);
		chk("low byte", d & 16'h00ff, 16'h0077);
		access_width_select <= 1'b1;
		bus(1'b0, {LOC_TIMER, 3'h4}, 16'h0000, d);
		chk("wide timer", d, 16'h1277);
		bus(1'b1, {LOC_TIMER, 3'h0}, 16'h0004, d);
		$display("test access width done");
		run(6);
		bus(1'b0, {LOC_INTSTAT, 3'h0}, 16'h0000, d);
		chk("int status", d, 16'h0007);
		chk("irq masked", {15'h0, irq}, 16'h0000);
		bus(1'b0, {LOC_LIMSTAT, 3'h0}, 16'h0000, d);
		chk("limit status", d, 16'h0004);
		chk("timer gap", 16'(gap[0] - gap[1]), 16'h0004);
		bus(1'b1, {LOC_INTEN, 3'h0}, 16'h2204, d);
		repeat (2) @(posedge clk_sys);
		chk("irq enabled", {15'h0, irq}, 16'h0001);
		drain();
		bus(1'b0, {LOC_INTSTAT, 3'h0}, 16'h0000, d);
		chk("ready status", d, 16'h0004);
		bus(1'b0, {LOC_INTSTAT, 3'h0}, 16'h0000, d);
		chk("status cleared", d, 16'h0000);
		repeat (2) @(posedge clk_sys);
		chk("irq idle", {15'h0, irq}, 16'h0000);
		lat <= 4'h9;
		run(n_done + 9);
		drain();
		run(n_done + 3);
		bus(1'b1, {LOC_CONFIG, 3'h0}, 16'h0082, d);
		exp_q.delete();
		pc_exp = 3'h0;
		bus(1'b0, {LOC_INTSTAT, 3'h0}, 16'h0000, d);
		chk("reset status", d, 16'h0000);
		bus(1'b0, {LOC_LIMSTAT, 3'h0}, 16'h0000, d);
		chk("reset limits", d, 16'h0000);
		bus(1'b0, {4'h0, 3'h0}, 16'h0000, d);
		chk("memory kept", d, 16'h00e1);
		lat <= 4'h1;
		run(n_done + 4);
		drain();
		print_verdict();
	end
endmodule : tb_top
